/* src/sim_mirror.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// pixel fifo, DEPTH must be a power of two
module sim_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;
    // ready is registered so the source never sees a comb path
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = count != '0;
    assign out_data = mem[rp];
    always_comb begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop & ~push) begin
            next_count = count - (AW+1)'(1);
        end
    end
    // pointers and fill level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) wp <= wp + AW'(1);
            if (pop) rp <= rp + AW'(1);
            count <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end
    // storage
    always_ff @(posedge mclk) begin
        if (push) mem[wp] <= in_data;
    end
endmodule

// ============================================================
// mirror stage
module sim_mirror import sim_pkg::*; #(
    parameter int BANK_WORDS = 65536,
    parameter sim_dim_type LINE_LIMIT = MIRROR_LINE_MAX
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pix_in_valid,
    input wire logic [PIX_W-1:0] pix_in_data,
    output logic pix_in_ready,
    output logic pix_out_valid,
    output sim_beat_type pix_out,
    input wire logic pix_out_ready
);
    localparam int ADDR_W = $clog2(BANK_WORDS);
    sim_origin_type view_origin;
    sim_dim_type full_line_pixels;
    sim_dim_type full_frame_lines;
    sim_dim_type roi_col_start;
    sim_dim_type roi_width;
    sim_dim_type roi_row_start;
    sim_dim_type roi_height;
    logic cfg_ok;
    logic write_rejected;
    logic [1:0] bank_full;
    logic wb;
    logic rb;
    sim_dim_type wcol;
    sim_dim_type wrow;
    sim_dim_type rcol;
    sim_dim_type orow;
    logic [PIX_W-1:0] mem [2*BANK_WORDS];

    // ========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nv, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = nv[8*i +: 8];
        end
        return r;
    endfunction
    function automatic logic in_range(input logic [31:0] v,
            input sim_dim_type lo, input sim_dim_type hi,
            input logic step8);
        return v[31:17] == '0 && v[16:0] >= lo && v[16:0] <= hi
            && (!step8 || v[2:0] == 3'h0);
    endfunction
    function automatic sim_dim_type wrap_inc(input sim_dim_type c,
            input logic last);
        return last ? '0 : c + 17'h00001;
    endfunction
    function automatic logic [ADDR_W-1:0] unit_addr(
            input sim_dim_type row, input sim_dim_type col,
            input sim_dim_type w);
        logic [33:0] a;
        a = 34'(row) * 34'(w) + 34'(col);
        return a[ADDR_W-1:0];
    endfunction

    // ========================================================
    // register bus
    logic [31:0] rd_mux;
    logic [31:0] wr_val;
    logic wr_go;
    logic wr_bad;
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            REG_ORIGIN: rd_mux = {30'h0, view_origin};
            REG_LINE_PIXELS: rd_mux = {15'h0, full_line_pixels};
            REG_FRAME_LINES: rd_mux = {15'h0, full_frame_lines};
            REG_COL_START: rd_mux = {15'h0, roi_col_start};
            REG_WIDTH: rd_mux = {15'h0, roi_width};
            REG_ROW_START: rd_mux = {15'h0, roi_row_start};
            REG_HEIGHT: rd_mux = {15'h0, roi_height};
            REG_STATUS: rd_mux = {28'h0, bank_full,
                write_rejected, cfg_ok};
            default: rd_mux = 32'h0;
        endcase
    end
    assign wr_go = avs_write & ~avs_waitrequest;
    assign wr_val = merge(rd_mux, avs_writedata, avs_byteenable);
    // out-of-range writes keep the old value
    always_comb begin
        wr_bad = 1'b0;
        case (avs_address)
            REG_LINE_PIXELS:
                wr_bad = !in_range(wr_val, MIN_LINE, MAX_LINE, 1'b1);
            REG_FRAME_LINES:
                wr_bad = !in_range(wr_val, MIN_LINES, MAX_LINES, 1'b0);
            REG_COL_START:
                wr_bad = !in_range(wr_val, '0, MAX_COL_START, 1'b1);
            REG_WIDTH:
                wr_bad = !in_range(wr_val, MIN_LINE, MAX_LINE, 1'b1);
            REG_ROW_START:
                wr_bad = !in_range(wr_val, '0, MAX_ROW_START, 1'b0);
            REG_HEIGHT:
                wr_bad = !in_range(wr_val, MIN_LINES, MAX_LINES, 1'b0);
            default: wr_bad = 1'b0;
        endcase
    end
    // one wait state on every access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= !((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) avs_readdata <= rd_mux;
        end
    end
    // settings
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            view_origin <= origin_upper_left;
            full_line_pixels <= RST_DIM;
            full_frame_lines <= RST_DIM;
            roi_col_start <= '0;
            roi_width <= RST_DIM;
            roi_row_start <= '0;
            roi_height <= RST_DIM;
        end else if (wr_go && !wr_bad) begin
            case (avs_address)
                REG_ORIGIN: view_origin <= sim_origin_type'(wr_val[1:0]);
                REG_LINE_PIXELS: full_line_pixels <= wr_val[16:0];
                REG_FRAME_LINES: full_frame_lines <= wr_val[16:0];
                REG_COL_START: roi_col_start <= wr_val[16:0];
                REG_WIDTH: roi_width <= wr_val[16:0];
                REG_ROW_START: roi_row_start <= wr_val[16:0];
                REG_HEIGHT: roi_height <= wr_val[16:0];
                default: ;
            endcase
        end
    end
    // sticky reject flag, a new reject beats the clear
    // clear looks at the raw lane so a merged old bit cannot clear it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_rejected <= 1'b0;
        end else if (wr_go && wr_bad) begin
            write_rejected <= 1'b1;
        end else if (wr_go && avs_address == REG_STATUS
                && avs_byteenable[0] && avs_writedata[ST_REJECT]) begin
            write_rejected <= 1'b0;
        end
    end

    // ========================================================
    // geometry
    logic hmode;
    logic vmode;
    logic mirror;
    sim_dim_type col_end;
    sim_dim_type row_end;
    sim_dim_type line_w;
    sim_dim_type frame_h;
    logic [33:0] unit_words;
    logic geo_ok;
    assign hmode = view_origin[0];
    assign vmode = view_origin[1];
    assign mirror = hmode | vmode;
    assign col_end = roi_col_start + roi_width;
    assign row_end = roi_row_start + roi_height;
    // full width only matters when mirroring left-right
    assign line_w = hmode ? full_line_pixels : col_end;
    // software must match the camera's line count here
    assign frame_h = vmode ? full_frame_lines : row_end;
    assign unit_words = vmode ? 34'(line_w) * 34'(frame_h) : 34'(line_w);
    always_comb begin
        geo_ok = 1'b1;
        if (hmode && col_end > full_line_pixels) geo_ok = 1'b0;
        // mirrored lines must fit the limited line storage
        if (hmode && full_line_pixels > LINE_LIMIT) begin
            geo_ok = 1'b0;
        end
        if (!hmode && col_end > MAX_LINE) geo_ok = 1'b0;
        if (vmode && row_end > full_frame_lines) geo_ok = 1'b0;
        if (mirror && unit_words > 34'(BANK_WORDS)) geo_ok = 1'b0;
    end
    // a bad geometry stalls the stream
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cfg_ok <= 1'b0;
        else cfg_ok <= geo_ok;
    end

    // ========================================================
    // input side: fifo, counters, bank writes
    logic [PIX_W-1:0] f_data;
    logic f_valid;
    logic pop;
    logic out_free;
    logic eol_w;
    logic eof_w;
    logic done_w;
    assign out_free = !pix_out_valid || pix_out_ready;
    assign pop = f_valid && cfg_ok
        && (mirror ? !bank_full[wb] : out_free);
    assign eol_w = wcol == line_w - 17'h00001;
    assign eof_w = eol_w && wrow == frame_h - 17'h00001;
    assign done_w = mirror && pop && eol_w && (!vmode || eof_w);
    sim_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(pix_in_valid),
        .in_ready(pix_in_ready),
        .in_data(pix_in_data),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );
    // position in the whole received image
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wcol <= '0;
            wrow <= '0;
        end else if (pop) begin
            wcol <= wrap_inc(wcol, eol_w);
            if (eol_w) wrow <= wrap_inc(wrow, eof_w);
        end
    end
    // bank store, a line per unit or a whole frame when flipping rows
    always_ff @(posedge mclk) begin
        if (pop && mirror) begin
            mem[{wb, unit_addr(vmode ? wrow : '0, wcol, line_w)}] <= f_data;
        end
    end

    // ========================================================
    // output side
    logic rd_go;
    logic eol_r;
    logic eof_r;
    logic done_r;
    logic [ADDR_W-1:0] raddr;
    assign rd_go = mirror && bank_full[rb] && out_free;
    assign eol_r = rcol == line_w - 17'h00001;
    assign eof_r = eol_r && orow == frame_h - 17'h00001;
    assign done_r = rd_go && eol_r && (!vmode || eof_r);
    assign raddr = unit_addr(
        vmode ? frame_h - 17'h00001 - orow : '0,
        hmode ? line_w - 17'h00001 - rcol : rcol, line_w);
    // banks: writer fills one while reader drains the other
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_full <= 2'h0;
            wb <= 1'b0;
            rb <= 1'b0;
        end else begin
            if (done_w) bank_full[wb] <= 1'b1;
            if (done_r) bank_full[rb] <= 1'b0;
            if (done_w) wb <= ~wb;
            if (done_r) rb <= ~rb;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rcol <= '0;
            orow <= '0;
        end else if (rd_go) begin
            rcol <= wrap_inc(rcol, eol_r);
            if (eol_r) orow <= wrap_inc(orow, eof_r);
        end
    end
    // output register, the memory read is registered straight into it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pix_out_valid <= 1'b0;
            pix_out <= '0;
        end else if (rd_go) begin
            pix_out_valid <= 1'b1;
            pix_out <= '{eof: eof_r, eol: eol_r, data: mem[{rb, raddr}]};
        end else if (pop && !mirror) begin
            pix_out_valid <= 1'b1;
            pix_out <= '{eof: eof_w, eol: eol_w, data: f_data};
        end else if (pix_out_ready) begin
            pix_out_valid <= 1'b0;
        end
    end

    // ========================================================
    // checks
    property p_origin_write;
        @(posedge mclk) disable iff (!rst_n)
        wr_go && avs_address == REG_ORIGIN
        |=> view_origin == $past(wr_val[1:0]);
    endproperty
    a_origin_write: assert property (p_origin_write)
        else $error("view origin write lost");
    property p_line_step;
        @(posedge mclk) disable iff (!rst_n)
        wr_go && avs_address == REG_LINE_PIXELS && wr_val[2:0] != 3'h0
        |=> $stable(full_line_pixels) && write_rejected;
    endproperty
    a_line_step: assert property (p_line_step)
        else $error("unaligned line width accepted");
    property p_lines_min;
        @(posedge mclk) disable iff (!rst_n)
        wr_go && avs_address == REG_FRAME_LINES && wr_val < 32'h2
        |=> $stable(full_frame_lines);
    endproperty
    a_lines_min: assert property (p_lines_min)
        else $error("frame lines below two accepted");
    property p_h_fit;
        @(posedge mclk) disable iff (!rst_n)
        hmode && col_end > full_line_pixels |=> !cfg_ok;
    endproperty
    a_h_fit: assert property (p_h_fit)
        else $error("window past full line accepted");
    property p_v_fit;
        @(posedge mclk) disable iff (!rst_n)
        vmode && row_end > full_frame_lines |=> !cfg_ok;
    endproperty
    a_v_fit: assert property (p_v_fit)
        else $error("window past full frame accepted");
    property p_h_limit;
        @(posedge mclk) disable iff (!rst_n)
        hmode && full_line_pixels > LINE_LIMIT |=> !cfg_ok ##1 !pop;
    endproperty
    a_h_limit: assert property (p_h_limit)
        else $error("overlong mirrored line accepted");
    property p_bypass_eol;
        @(posedge mclk) disable iff (!rst_n)
        pop && !mirror && eol_w |=> pix_out_valid && pix_out.eol;
    endproperty
    a_bypass_eol: assert property (p_bypass_eol)
        else $error("unmirrored line end misplaced");
    property p_bank_swap;
        @(posedge mclk) disable iff (!rst_n)
        done_w |=> bank_full[$past(wb)] && wb != $past(wb);
    endproperty
    a_bank_swap: assert property (p_bank_swap)
        else $error("stored unit not handed to reader");
    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed while stalled");
endmodule
`default_nettype wire

/* src/sim_pkg.sv */
// Function
// - four view origins, reset to upper left
// - mirror whole received image, not window
// - h-mirror: column start plus width fits line
// - v-mirror: row start plus height fits frame
// - full line width used only for h-mirror
// - v-mirror: frame fits twice in bank memory
// - unmirrored line width is start plus width
// - line width 8..32768 step 8, reset 1024
// - frame lines 2..65536 step 1, reset 1024
// - no v-mirror: height is start plus height
// - h-mirrored line width at most 8192
`default_nettype none
package sim_pkg;
    // ========================================================
    // types
    typedef enum logic [1:0] {
        origin_upper_left,
        origin_upper_right,
        origin_lower_left,
        origin_lower_right
    } sim_origin_type;
    localparam int PIX_W = 16;
    localparam int FIFO_DEPTH = 8;
    typedef logic [16:0] sim_dim_type;
    typedef struct packed {
        logic eof;
        logic eol;
        logic [PIX_W-1:0] data;
    } sim_beat_type;
    // ========================================================
    // register byte offsets
    localparam logic [5:0] REG_ORIGIN = 6'h00;
    localparam logic [5:0] REG_LINE_PIXELS = 6'h04;
    localparam logic [5:0] REG_FRAME_LINES = 6'h08;
    localparam logic [5:0] REG_COL_START = 6'h0C;
    localparam logic [5:0] REG_WIDTH = 6'h10;
    localparam logic [5:0] REG_ROW_START = 6'h14;
    localparam logic [5:0] REG_HEIGHT = 6'h18;
    localparam logic [5:0] REG_STATUS = 6'h1C;
    // status bit positions
    localparam int ST_OK = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_FULL = 2;
    // ========================================================
    // reset values and limits
    localparam sim_dim_type RST_DIM = 17'h00400;
    localparam sim_dim_type MIN_LINE = 17'h00008;
    localparam sim_dim_type MAX_LINE = 17'h08000;
    localparam sim_dim_type MAX_COL_START = 17'h07FF8;
    localparam sim_dim_type MIN_LINES = 17'h00002;
    localparam sim_dim_type MAX_LINES = 17'h10000;
    localparam sim_dim_type MAX_ROW_START = 17'h0FFFF;
    localparam sim_dim_type MIRROR_LINE_MAX = 17'h02000;
endpackage
`default_nettype wire

/* dv/sim_camera_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// camera model: one raster frame of beats per go pulse
module sim_camera_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic [16:0] beats,
    output logic valid,
    output logic [15:0] data,
    input wire logic ready,
    output logic busy
);
    logic [16:0] sent;

    // exact beat count of the frame, raster order
    // gaps show the inverted value so a stale pixel never looks valid
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            busy <= 1'b0;
            data <= 16'h0000;
            sent <= 17'h00000;
        end else if (go && !busy) begin
            busy <= 1'b1;
            valid <= 1'b1;
            data <= 16'hA000;
            sent <= 17'h00000;
        end else if (valid && ready) begin
            sent <= sent + 17'h00001;
            if (sent + 17'h00001 == beats) begin
                valid <= 1'b0;
                busy <= 1'b0;
                data <= ~data;
            end else if (slow) begin
                valid <= 1'b0;
                data <= ~(data + 16'h0001);
            end else begin
                data <= data + 16'h0001;
            end
        end else if (busy && !valid) begin
            valid <= 1'b1;
            data <= ~data;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_sim_mirror.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_sim_mirror import sim_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pix_in_valid;
    logic [PIX_W-1:0] pix_in_data;
    logic pix_in_ready;
    logic pix_out_valid;
    sim_beat_type pix_out;
    logic pix_out_ready = 1'b1;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [16:0] beats = 17'h00001;
    logic cam_busy;
    int num_errors = 0;
    int cmp_count = 0;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;

    // ========================================================
    // clock, design and camera
    always #4 mclk = ~mclk;

    sim_mirror #(.BANK_WORDS(256), .LINE_LIMIT(17'h00010)) dut (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
        .pix_in_ready(pix_in_ready), .pix_out_valid(pix_out_valid),
        .pix_out(pix_out), .pix_out_ready(pix_out_ready)
    );

    sim_camera_model cam (
        .mclk(mclk), .rst_n(rst_n), .go(go), .slow(slow), .beats(beats),
        .valid(pix_in_valid), .data(pix_in_data), .ready(pix_in_ready),
        .busy(cam_busy)
    );

    // ========================================================
    // shared helpers
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask

    task hang(input string what);
        $display("wrong value %s expected done seen timeout", what);
        num_errors++;
        close_out;
    endtask

    // request held until waitrequest is sampled low, then released
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) hang("bus");
        @(posedge mclk);
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task rd(input string what, input logic [5:0] a, input logic [31:0] e,
            input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(what, e & m, q & m);
    endtask

    // one frame from the camera, output compared beat by beat
    task run_frame(input bit hf, input bit vf, input int w, input int h);
        int k, cyc, r, c, sr, sc;
        logic [17:0] e;
        beats <= 17'(w * h);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        k = 0;
        cyc = 0;
        while (k < w * h && cyc < 3000) begin
            @(posedge mclk);
            cyc++;
            if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
                r = k / w;
                c = k % w;
                sr = vf ? h - 1 - r : r;
                sc = hf ? w - 1 - c : c;
                e = {k == w * h - 1, c == w - 1, 16'(16'hA000 + sr * w + sc)};
                if (vf && k == 0) begin
                    chk("early", 0, 32'(cam_busy));
                end
                chk("pix_out", 32'(e), 32'(pix_out));
                k++;
            end
            pix_out_ready <= (cyc % 4 != 3);
        end
        if (k < w * h) hang("frame");
    endtask

    // ========================================================
    // scenarios
    task t_reset;
        rd("origin", REG_ORIGIN, 32'h00000000, ALL);
        rd("line", REG_LINE_PIXELS, 32'h00000400, ALL);
        rd("frame", REG_FRAME_LINES, 32'h00000400, ALL);
        rd("status", REG_STATUS, 32'h00000001, 32'h00000003);
        rd("unmapped", 6'h20, 32'h00000000, ALL);
        $display("test reset done");
    endtask

    task t_range;
        wr(REG_LINE_PIXELS, 32'h0000000C);
        rd("line", REG_LINE_PIXELS, 32'h00000400, ALL);
        rd("status", REG_STATUS, 32'h00000003, 32'h00000003);
        wr(REG_STATUS, 32'h00000002);
        wr(REG_FRAME_LINES, 32'h00000001);
        rd("frame", REG_FRAME_LINES, 32'h00000400, ALL);
        rd("status", REG_STATUS, 32'h00000003, 32'h00000003);
        wr(REG_STATUS, 32'h00000002);
        wr(REG_LINE_PIXELS, 32'h00008000);
        rd("line", REG_LINE_PIXELS, 32'h00008000, ALL);
        wr(REG_FRAME_LINES, 32'h00010000);
        rd("frame", REG_FRAME_LINES, 32'h00010000, ALL);
        rd("status", REG_STATUS, 32'h00000001, 32'h00000003);
        $display("test range done");
    endtask

    // line 8+8, frame 1+2: full-size settings must not matter
    task t_plain;
        wr(REG_COL_START, 32'h00000008);
        wr(REG_WIDTH, 32'h00000008);
        wr(REG_ROW_START, 32'h00000001);
        wr(REG_HEIGHT, 32'h00000002);
        run_frame(0, 0, 16, 3);
        $display("test plain done");
    endtask

    task t_flips;
        wr(REG_LINE_PIXELS, 32'h00000010);
        wr(REG_ORIGIN, 32'h00000001);
        run_frame(1, 0, 16, 3);
        wr(REG_LINE_PIXELS, 32'h00008000);
        wr(REG_FRAME_LINES, 32'h00000004);
        wr(REG_ORIGIN, 32'h00000002);
        slow <= 1'b1;
        run_frame(0, 1, 16, 4);
        slow <= 1'b0;
        wr(REG_LINE_PIXELS, 32'h00000010);
        wr(REG_ORIGIN, 32'h00000003);
        run_frame(1, 1, 16, 4);
        run_frame(1, 1, 16, 4);
        $display("test flips done");
    endtask

    task t_geom;
        int n;
        wr(REG_WIDTH, 32'h00000010);
        rd("status", REG_STATUS, 32'h00000000, 32'h00000001);
        wr(REG_WIDTH, 32'h00000008);
        wr(REG_LINE_PIXELS, 32'h00000018);
        rd("status", REG_STATUS, 32'h00000000, 32'h00000001);
        wr(REG_LINE_PIXELS, 32'h00000010);
        wr(REG_FRAME_LINES, 32'h00000002);
        rd("status", REG_STATUS, 32'h00000000, 32'h00000001);
        wr(REG_FRAME_LINES, 32'h00000010);
        rd("status", REG_STATUS, 32'h00000001, 32'h00000001);
        wr(REG_FRAME_LINES, 32'h00000011);
        rd("status", REG_STATUS, 32'h00000000, 32'h00000001);
        // stream stalls: the fifo fills and then refuses
        beats <= 17'h00028;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        n = 0;
        repeat (60) begin
            @(posedge mclk);
            if (pix_in_valid === 1'b1 && pix_in_ready === 1'b1) n++;
        end
        chk("taken", FIFO_DEPTH, n);
        chk("out_valid", 0, 32'(pix_out_valid));
        // second reset in mid-run restores defaults
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd("origin", REG_ORIGIN, 32'h00000000, ALL);
        rd("status", REG_STATUS, 32'h00000001, 32'h00000003);
        $display("test geometry done");
    endtask

    // ========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset;
        t_range;
        t_plain;
        t_flips;
        t_geom;
        close_out;
    end
endmodule
`default_nettype wire
